// ---- core/hbd_consts.vh ----
// Shared constants of the H-bridge mode decoder and chopper
`ifndef HBD_CONSTS_VH
`define HBD_CONSTS_VH

// ----------------------------------------------------------------
// Register map (byte addresses, AXI4-Lite)
// ----------------------------------------------------------------
`define HBD_ADDR_W        5
`define HBD_OFF_CTRL      5'h00
`define HBD_OFF_STATUS    5'h04
`define HBD_OFF_MASK      5'h08
`define HBD_OFF_STATE     5'h0C

// Control fields
`define HBD_CTRL_W        4
`define HBD_CTRL_RST      4'h4
`define HBD_TOFF_LSB      0
`define HBD_TOFF_MSB      1
`define HBD_GAIN_LSB      2
`define HBD_GAIN_MSB      3
`define HBD_GAIN_FIXED    2'h1

// Sticky event bits
`define HBD_EV_W          3
`define HBD_EV_CHOP       0
`define HBD_EV_FAULT      1
`define HBD_EV_MODE       2
`define HBD_EV_RST        3'h0

// Latched interface modes
`define HBD_MODE_PHEN     2'h0
`define HBD_MODE_INDEP    2'h1
`define HBD_MODE_PWM      2'h2

// Gate patterns {highLeft, lowLeft, highRight, lowRight}
`define HBD_GATES_COAST   4'h0
`define HBD_GATES_FWD     4'h9
`define HBD_GATES_REV     4'h6
`define HBD_GATES_BRAKE   4'h5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HBD_CLK_MHZ       12'h014
`define HBD_BLANK_US      12'h002
`define HBD_TOFF0_US      12'h019
`define HBD_TOFF1_US      12'h032
`define HBD_TOFF2_US      12'h064
`define HBD_TOFF3_US      12'h0C8
`define HBD_BLANK_CYC     (`HBD_BLANK_US * `HBD_CLK_MHZ)
`define HBD_TOFF0_CYC     (`HBD_TOFF0_US * `HBD_CLK_MHZ)
`define HBD_TOFF1_CYC     (`HBD_TOFF1_US * `HBD_CLK_MHZ)
`define HBD_TOFF2_CYC     (`HBD_TOFF2_US * `HBD_CLK_MHZ)
`define HBD_TOFF3_CYC     (`HBD_TOFF3_US * `HBD_CLK_MHZ)
`define HBD_CNT_W         12

// Synchroniser lanes
`define HBD_SYNC_W        7
`define HBD_SY_SLEEP      0
`define HBD_SY_INA        1
`define HBD_SY_INB        2
`define HBD_SY_MLVL       3
`define HBD_SY_MFLT       4
`define HBD_SY_TRIP       5
`define HBD_SY_FAULT      6

// AXI responses
`define HBD_RESP_OKAY     2'h0
`define HBD_RESP_SLVERR   2'h2

`endif

// ---- core/hbd_sync.v ----
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module hbd_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk,
    input  wire             nrst,
    // Data
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] stab_ff;

    // First stage feeds only the second stage
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= {WIDTH{1'b0}};
            stab_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= din;
            stab_ff <= meta_ff;
        end
    end

    assign dout = stab_ff;

endmodule // hbd_sync

`default_nettype wire

// ---- core/hbd_bridge.v ----
// H-bridge interface decoder, power sequencer and current chopper
//
// Functional notes
// - Strap sampled only at power-up and sleep exit
// - Strap low PH/EN, high independent, float PWM
// - Sleep: bridge off, inputs ignored, regulators off
// - PH/EN: enable low brakes, phase picks direction
// - Independent: each input drives its own half-bridge
// - PWM: 00 coast, 01 reverse, 10 forward, 11 brake
// - Forward drives left node high, right low
// - Logic regulator, then strap latch, then analog
// - Fault pulls open-drain flag low, else released
// - Trip during drive brakes for off-time, resumes
// - Sense ignored for blanking after drive enabled
// - Amplifier gain selectable, else fixed at 19.8
// - Independent mode never chops
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`include "hbd_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module hbd_bridge #(
    parameter GAIN_CFG = 1
) (
    // Clock and reset
    input  wire                   clk,
    input  wire                   nrst,
    // Pins from the controller and analog front end
    input  wire                   sleepBar,
    input  wire                   bridgeInA,
    input  wire                   bridgeInB,
    input  wire                   modeStrapLvl,
    input  wire                   modeStrapFloat,
    input  wire                   chopTrip,
    input  wire                   faultDetect,
    // Gate commands and supplies
    output reg                    highGateLeft,
    output reg                    lowGateLeft,
    output reg                    highGateRight,
    output reg                    lowGateRight,
    output reg                    bridgeDriveEn,
    output reg                    logicRegEn,
    output reg                    analogRegEn,
    output reg  [1:0]             ampGainSel,
    // Open-drain fault flag and interrupt
    output reg                    faultFlagLowO,
    output reg                    faultFlagLowOeN,
    output reg                    irq,
    // AXI4-Lite write channels
    input  wire [`HBD_ADDR_W-1:0] awaddr,
    input  wire                   awvalid,
    output reg                    awready,
    input  wire [31:0]            wdata,
    input  wire [3:0]             wstrb,
    input  wire                   wvalid,
    output reg                    wready,
    output reg  [1:0]             bresp,
    output reg                    bvalid,
    input  wire                   bready,
    // AXI4-Lite read channels
    input  wire [`HBD_ADDR_W-1:0] araddr,
    input  wire                   arvalid,
    output reg                    arready,
    output reg  [31:0]            rdata,
    output reg  [1:0]             rresp,
    output reg                    rvalid,
    input  wire                   rready
);

    // ----------------------------------------------------------------
    // Local constants
    // ----------------------------------------------------------------
    localparam [3:0] SEQ_OFF   = 4'h1;
    localparam [3:0] SEQ_LOGIC = 4'h2;
    localparam [3:0] SEQ_LATCH = 4'h4;
    localparam [3:0] SEQ_RUN   = 4'h8;

    localparam [3:0] CH_IDLE  = 4'h1;
    localparam [3:0] CH_BLANK = 4'h2;
    localparam [3:0] CH_ARMED = 4'h4;
    localparam [3:0] CH_OFF   = 4'h8;

    localparam [`HBD_CNT_W-1:0] CNT_ZERO   = {`HBD_CNT_W{1'b0}};
    localparam [`HBD_CNT_W-1:0] CNT_ONE    = {{(`HBD_CNT_W-1){1'b0}}, 1'b1};
    localparam [`HBD_CNT_W-1:0] BLANK_LAST = `HBD_BLANK_CYC - CNT_ONE;
    localparam [`HBD_CNT_W-1:0] TOFF0_LAST = `HBD_TOFF0_CYC - CNT_ONE;
    localparam [`HBD_CNT_W-1:0] TOFF1_LAST = `HBD_TOFF1_CYC - CNT_ONE;
    localparam [`HBD_CNT_W-1:0] TOFF2_LAST = `HBD_TOFF2_CYC - CNT_ONE;
    localparam [`HBD_CNT_W-1:0] TOFF3_LAST = `HBD_TOFF3_CYC - CNT_ONE;

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    wire [`HBD_SYNC_W-1:0] pinRaw;
    wire [`HBD_SYNC_W-1:0] pinSync;

    assign pinRaw = {faultDetect, chopTrip, modeStrapFloat, modeStrapLvl,
                     bridgeInB, bridgeInA, sleepBar};

    // Trip arrives on the same two flops as every other pin
    hbd_sync #(
        .WIDTH (`HBD_SYNC_W)
    ) uSync (
        .clk  (clk),
        .nrst (nrst),
        .din  (pinRaw),
        .dout (pinSync)
    );

    wire sleepS = pinSync[`HBD_SY_SLEEP];
    wire inAS   = pinSync[`HBD_SY_INA];
    wire inBS   = pinSync[`HBD_SY_INB];
    wire mLvlS  = pinSync[`HBD_SY_MLVL];
    wire mFltS  = pinSync[`HBD_SY_MFLT];
    wire tripS  = pinSync[`HBD_SY_TRIP];
    wire faultS = pinSync[`HBD_SY_FAULT];

    // ----------------------------------------------------------------
    // State declarations
    // ----------------------------------------------------------------
    reg [3:0]             seq_ff;
    reg [3:0]             nxt_seq;
    reg [1:0]             mode_ff;
    reg                   modeEv;
    reg [3:0]             ch_ff;
    reg [3:0]             nxt_ch;
    reg [`HBD_CNT_W-1:0]  cnt_ff;
    reg [`HBD_CNT_W-1:0]  nxt_cnt;
    reg [1:0]             dir_ff;
    reg                   chopEv;
    reg                   faultPrev_ff;
    reg [`HBD_CTRL_W-1:0] ctrl_ff;
    reg [`HBD_EV_W-1:0]   status_ff;
    reg [`HBD_EV_W-1:0]   mask_ff;
    reg [`HBD_EV_W-1:0]   nxt_status;
    reg [3:0]             reqGates;
    reg [3:0]             outGates;
    reg [`HBD_CNT_W-1:0]  toffLast;

    // ----------------------------------------------------------------
    // Power-up and sleep sequencer
    // ----------------------------------------------------------------
    // Sleep entry always returns to OFF so wake re-runs the sequence
    always @* begin
        nxt_seq = seq_ff;
        case (seq_ff)
            SEQ_OFF:   if (sleepS) nxt_seq = SEQ_LOGIC;
            SEQ_LOGIC: nxt_seq = sleepS ? SEQ_LATCH : SEQ_OFF;
            SEQ_LATCH: nxt_seq = sleepS ? SEQ_RUN : SEQ_OFF;
            SEQ_RUN:   if (!sleepS) nxt_seq = SEQ_OFF;
            default:   nxt_seq = SEQ_OFF;
        endcase
        modeEv = (seq_ff == SEQ_LATCH) && sleepS;
    end

    // Regulators follow the sequence, logic before analog
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_ff      <= SEQ_OFF;
            logicRegEn  <= 1'b0;
            analogRegEn <= 1'b0;
        end else begin
            seq_ff      <= nxt_seq;
            logicRegEn  <= (nxt_seq != SEQ_OFF);
            analogRegEn <= (nxt_seq == SEQ_RUN);
        end
    end

    // Strap is read in one state only and then held
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_ff <= `HBD_MODE_PHEN;
        end else if (modeEv) begin
            if (mFltS) begin
                mode_ff <= `HBD_MODE_PWM;
            end else if (mLvlS) begin
                mode_ff <= `HBD_MODE_INDEP;
            end else begin
                mode_ff <= `HBD_MODE_PHEN;
            end
        end
    end

    wire running = (seq_ff == SEQ_RUN);

    // ----------------------------------------------------------------
    // Input decode
    // ----------------------------------------------------------------
    always @* begin
        reqGates = `HBD_GATES_COAST;
        case (mode_ff)
            `HBD_MODE_PHEN: begin
                if (!inBS) begin
                    reqGates = `HBD_GATES_BRAKE;
                end else if (inAS) begin
                    reqGates = `HBD_GATES_FWD;
                end else begin
                    reqGates = `HBD_GATES_REV;
                end
            end
            `HBD_MODE_INDEP: begin
                reqGates = {inAS, ~inAS, inBS, ~inBS};
            end
            `HBD_MODE_PWM: begin
                case ({inAS, inBS})
                    2'b01:   reqGates = `HBD_GATES_REV;
                    2'b10:   reqGates = `HBD_GATES_FWD;
                    2'b11:   reqGates = `HBD_GATES_BRAKE;
                    default: reqGates = `HBD_GATES_COAST;
                endcase
            end
            default: reqGates = `HBD_GATES_COAST;
        endcase
    end

    // Direction of a full-bridge drive; independent mode never counts
    wire        chopMode = (mode_ff != `HBD_MODE_INDEP);
    wire        reqFwd   = (reqGates == `HBD_GATES_FWD);
    wire        reqRev   = (reqGates == `HBD_GATES_REV);
    wire [1:0]  dirNow   = {reqFwd, reqRev};
    wire        driving  = running && chopMode && (reqFwd || reqRev);

    // ----------------------------------------------------------------
    // Fixed off-time chopper
    // ----------------------------------------------------------------
    // Off-time setting is taken live; a change also applies to an off-time already running
    always @* begin
        case (ctrl_ff[`HBD_TOFF_MSB:`HBD_TOFF_LSB])
            2'h0:    toffLast = TOFF0_LAST;
            2'h1:    toffLast = TOFF1_LAST;
            2'h2:    toffLast = TOFF2_LAST;
            default: toffLast = TOFF3_LAST;
        endcase
    end

    // A fresh or reversed drive restarts the blanking window
    always @* begin
        nxt_ch  = ch_ff;
        nxt_cnt = cnt_ff;
        chopEv  = 1'b0;
        if (!driving) begin
            nxt_ch  = CH_IDLE;
            nxt_cnt = CNT_ZERO;
        end else if (dirNow != dir_ff) begin
            nxt_ch  = CH_BLANK;
            nxt_cnt = CNT_ZERO;
        end else begin
            case (ch_ff)
                CH_BLANK: begin
                    if (cnt_ff == BLANK_LAST) begin
                        nxt_ch  = CH_ARMED;
                        nxt_cnt = CNT_ZERO;
                    end else begin
                        nxt_cnt = cnt_ff + CNT_ONE;
                    end
                end
                CH_ARMED: begin
                    if (tripS) begin
                        nxt_ch  = CH_OFF;
                        nxt_cnt = CNT_ZERO;
                        chopEv  = 1'b1;
                    end
                end
                CH_OFF: begin
                    if (cnt_ff == toffLast) begin
                        nxt_ch  = CH_BLANK;
                        nxt_cnt = CNT_ZERO;
                    end else begin
                        nxt_cnt = cnt_ff + CNT_ONE;
                    end
                end
                default: begin
                    nxt_ch  = CH_BLANK;
                    nxt_cnt = CNT_ZERO;
                end
            endcase
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ch_ff  <= CH_IDLE;
            cnt_ff <= CNT_ZERO;
            dir_ff <= 2'b00;
        end else begin
            ch_ff  <= nxt_ch;
            cnt_ff <= nxt_cnt;
            dir_ff <= driving ? dirNow : 2'b00;
        end
    end

    // ----------------------------------------------------------------
    // Gate outputs
    // ----------------------------------------------------------------
    // Coast unless running, brake during off-time, otherwise the decoded pattern passes
    always @* begin
        if (!running) begin
            outGates = `HBD_GATES_COAST;
        end else if (nxt_ch == CH_OFF) begin
            outGates = `HBD_GATES_BRAKE;
        end else begin
            outGates = reqGates;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            highGateLeft  <= 1'b0;
            lowGateLeft   <= 1'b0;
            highGateRight <= 1'b0;
            lowGateRight  <= 1'b0;
            bridgeDriveEn <= 1'b0;
        end else begin
            highGateLeft  <= outGates[3];
            lowGateLeft   <= outGates[2];
            highGateRight <= outGates[1];
            lowGateRight  <= outGates[0];
            bridgeDriveEn <= running;
        end
    end

    // Open-drain flag: data stays low, enable active low drives it
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            faultFlagLowO   <= 1'b0;
            faultFlagLowOeN <= 1'b1;
            faultPrev_ff    <= 1'b0;
        end else begin
            faultFlagLowO   <= 1'b0;
            faultFlagLowOeN <= ~faultS;
            faultPrev_ff    <= faultS;
        end
    end

    // Gain code to the amplifier; fixed variant ignores the field
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ampGainSel <= `HBD_GAIN_FIXED;
        end else if (GAIN_CFG != 0) begin
            ampGainSel <= ctrl_ff[`HBD_GAIN_MSB:`HBD_GAIN_LSB];
        end else begin
            ampGainSel <= `HBD_GAIN_FIXED;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    reg                   awHeld_ff;
    reg                   wHeld_ff;
    reg [`HBD_ADDR_W-1:0] awAddr_ff;
    reg [31:0]            wData_ff;
    reg                   wLane0_ff;
    reg [31:0]            rdMux;
    reg                   rdHit;

    wire doWrite = awHeld_ff && wHeld_ff && !bvalid;
    wire wrHit   = (awAddr_ff == `HBD_OFF_CTRL) ||
                   (awAddr_ff == `HBD_OFF_STATUS) ||
                   (awAddr_ff == `HBD_OFF_MASK) ||
                   (awAddr_ff == `HBD_OFF_STATE);
    wire wrOk    = doWrite && wLane0_ff;
    wire wrCtrl  = wrOk && (awAddr_ff == `HBD_OFF_CTRL);
    wire wrStat  = wrOk && (awAddr_ff == `HBD_OFF_STATUS);
    wire wrMask  = wrOk && (awAddr_ff == `HBD_OFF_MASK);

    // Address and data may come in either order; one write at a time
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            awAddr_ff <= {`HBD_ADDR_W{1'b0}};
            wData_ff  <= 32'h00000000;
            wLane0_ff <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `HBD_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready   <= 1'b0;
                awHeld_ff <= 1'b1;
                awAddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                wready    <= 1'b0;
                wHeld_ff  <= 1'b1;
                wData_ff  <= wdata;
                wLane0_ff <= wstrb[0];
            end
            if (doWrite) begin
                awHeld_ff <= 1'b0;
                wHeld_ff  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= wrHit ? `HBD_RESP_OKAY : `HBD_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Read mux; the state word shows live block state
    always @* begin
        rdHit = 1'b1;
        case (araddr)
            `HBD_OFF_CTRL:   rdMux = {28'h0000000, ctrl_ff};
            `HBD_OFF_STATUS: rdMux = {29'h00000000, status_ff};
            `HBD_OFF_MASK:   rdMux = {29'h00000000, mask_ff};
            `HBD_OFF_STATE:  rdMux = {26'h0000000, running, faultS,
                                      (ch_ff == CH_OFF), ~sleepS, mode_ff};
            default: begin
                rdMux = 32'h00000000;
                rdHit = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `HBD_RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rdMux;
                rresp   <= rdHit ? `HBD_RESP_OKAY : `HBD_RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control, status and interrupt
    // ----------------------------------------------------------------
    // Write-one-to-clear, but a same-cycle event keeps its bit
    always @* begin
        nxt_status = status_ff;
        if (wrStat) begin
            nxt_status = status_ff & ~wData_ff[`HBD_EV_W-1:0];
        end
        nxt_status[`HBD_EV_CHOP]  = nxt_status[`HBD_EV_CHOP]  | chopEv;
        nxt_status[`HBD_EV_FAULT] = nxt_status[`HBD_EV_FAULT] |
                                    (faultS & ~faultPrev_ff);
        nxt_status[`HBD_EV_MODE]  = nxt_status[`HBD_EV_MODE]  | modeEv;
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff   <= `HBD_CTRL_RST;
            mask_ff   <= `HBD_EV_RST;
            status_ff <= `HBD_EV_RST;
            irq       <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrl_ff <= wData_ff[`HBD_CTRL_W-1:0];
            end
            if (wrMask) begin
                mask_ff <= wData_ff[`HBD_EV_W-1:0];
            end
            status_ff <= nxt_status;
            irq       <= |(nxt_status & mask_ff);
        end
    end

endmodule // hbd_bridge

`default_nettype wire

// ---- tb/hbd_bridge_properties.sv ----
// Checker of gate, supply and fault flag behaviour at the bridge ports
`timescale 1ns/1ps
`default_nettype none
module hbd_bridge_chk (
    // Clock, reset and pins
    input wire logic       clk, nrst, sleepBar, faultDetect,
    // Gates, supplies and flag
    input wire logic       highGateLeft, lowGateLeft, highGateRight,
    input wire logic       lowGateRight, bridgeDriveEn, logicRegEn,
    input wire logic       analogRegEn, faultFlagLowO, faultFlagLowOeN,
    // Write answer
    input wire logic       bvalid, bready,
    input wire logic [1:0] bresp
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Pins cross two sync flops and two registers, so five cycles settle
    wire gateOn = highGateLeft | lowGateLeft | highGateRight | lowGateRight;
    sequence asleep; !sleepBar [*5]; endsequence
    sequence logicUp; $rose(logicRegEn); endsequence
    sleep_off_a: assert property (
        asleep |-> !gateOn && !logicRegEn && !analogRegEn)
        else $error("Bridge on in sleep");
    idle_gates_a: assert property (
        !bridgeDriveEn |-> !gateOn) else $error("Gate on while off");
    analog_late_a: assert property (
        logicUp |-> !analogRegEn [*2]) else $error("Analog too early");
    analog_after_a: assert property (
        $rose(analogRegEn) |-> $past(logicRegEn, 2))
        else $error("Analog before logic");
    no_shoot_a: assert property (
        !(highGateLeft && lowGateLeft) && !(highGateRight && lowGateRight))
        else $error("Half bridge shorted");
    flag_pull_a: assert property (
        faultDetect [*4] |-> !faultFlagLowOeN && !faultFlagLowO)
        else $error("Flag not pulled");
    flag_free_a: assert property (
        !faultDetect [*4] |-> faultFlagLowOeN) else $error("Flag held");
    resp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("Response dropped");
endmodule // hbd_bridge_chk
bind hbd_bridge hbd_bridge_chk u_chk (.*);
`default_nettype wire

// ---- tb/hbd_ctrl_model.sv ----
// Behavioural controller driving bridge inputs, sleep and mode strap
`timescale 1ns/1ps
`default_nettype none
module hbd_ctrl_model (
    // Clock and command {float, level, wake, a, b}
    input  wire logic       clk,
    input  wire logic [4:0] cmd,
    // Pins towards the bridge
    output var logic        sleepBar,
    output var logic        bridgeInA,
    output var logic        bridgeInB,
    output var logic        modeStrapLvl,
    output var logic        modeStrapFloat
);
    // Awake with strap low at power-up
    initial {modeStrapFloat, modeStrapLvl, sleepBar, bridgeInA,
        bridgeInB} = 5'h04;
    // Commands land one edge later, like a port write in firmware
    always @(posedge clk) begin
        sleepBar <= cmd[2];
        bridgeInA <= cmd[1];
        bridgeInB <= cmd[0];
        modeStrapFloat <= cmd[4];
        // A released strap drifts, so its level never holds a value
        modeStrapLvl <= cmd[4] ? ~modeStrapLvl : cmd[3];
    end
endmodule // hbd_ctrl_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the bridge decoder and chopper
`timescale 1ns/1ps
`default_nettype none
`include "hbd_consts.vh"
module testbench;
    // Stimulus and bus master drive
    logic clk = 0, nrst = 0, chopTrip = 0, faultDetect = 0;
    logic [4:0] cmd = 5'h04, awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rd;
    logic [3:0] wstrb = 4'hF, gates;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [1:0] rsp;
    // Design and model outputs
    wire logic sleepBar, bridgeInA, bridgeInB, modeStrapLvl, modeStrapFloat;
    wire logic highGateLeft, lowGateLeft, highGateRight, lowGateRight;
    wire logic bridgeDriveEn, logicRegEn, analogRegEn, irq, awready;
    wire logic faultFlagLowO, faultFlagLowOeN, wready, bvalid, arready;
    wire logic [1:0] ampGainSel, bresp, rresp;
    wire logic rvalid;
    wire logic [31:0] rdata;
    // Gates by {a,b}: phase/enable, pwm, independent
    logic [3:0] tbl [3][4] = '{'{4'h5, 4'h6, 4'h5, 4'h9},
        '{4'h0, 4'h6, 4'h9, 4'h5}, '{4'h5, 4'h6, 4'h9, 4'hA}};
    int n_mismatch = 0, total_checks = 0, cyc = 0, k;
    assign gates = {highGateLeft, lowGateLeft, highGateRight, lowGateRight};
    hbd_bridge DUT (.*);
    hbd_ctrl_model ctrl (.*);
    initial forever #25 clk = ~clk;
    // Hang guard, far past the roughly one thousand cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // Bus cycles: hold each channel until its ready, wait for the answer
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        rsp = bresp;
    endtask
    task automatic rdr(input logic [4:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rd = rdata; rsp = rresp;
    endtask
    task automatic pins(input logic [4:0] c);
        cmd <= c;
        repeat (8) @(posedge clk);
    endtask
    task automatic runTable(input int t, input logic [2:0] hi);
        for (int i = 0; i < 4; i++) begin
            pins({hi, i[1:0]});
            chk("gates", tbl[t][i], gates);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1;
        repeat (12) @(posedge clk);
        chk("supplies", 3'h7, {logicRegEn, analogRegEn, bridgeDriveEn});
        rdr(`HBD_OFF_CTRL); chk("ctrl", 32'h4, rd);
        rdr(`HBD_OFF_MASK); chk("mask", 0, rd);
        rdr(`HBD_OFF_STATE); chk("mode", `HBD_MODE_PHEN, rd[1:0]);
        rdr(5'h10); chk("unmapped", `HBD_RESP_SLVERR, rsp);
        wr(5'h10, 32'h0); chk("wr unmapped", `HBD_RESP_SLVERR, rsp);
        wr(`HBD_OFF_MASK, 32'h7);
        runTable(0, 3'h1);
        // Trip held high while drive starts: blanking must hide it
        chopTrip <= 1;
        pins(5'h06);
        cmd <= 5'h07;
        for (k = 0; gates !== `HBD_GATES_FWD && k < 20; k++) @(posedge clk);
        for (k = 0; gates !== `HBD_GATES_BRAKE && k < 200; k++) @(posedge clk);
        chk("blank", 1, k >= `HBD_BLANK_CYC - 2 && k <= `HBD_BLANK_CYC + 5);
        for (k = 0; gates === `HBD_GATES_BRAKE && k < 6000; k++) @(posedge clk);
        chk("off", 1, k >= `HBD_TOFF0_CYC - 2 && k <= `HBD_TOFF0_CYC + 2);
        chk("resume", `HBD_GATES_FWD, gates);
        chopTrip <= 0;
        rdr(`HBD_OFF_STATUS); chk("chop event", 1, rd[`HBD_EV_CHOP]);
        chk("irq", 1, irq);
        wr(`HBD_OFF_STATUS, 32'h7);
        repeat (3) @(posedge clk);
        chk("irq clear", 0, irq);
        faultDetect <= 1;
        repeat (6) @(posedge clk);
        chk("flag", 2'h0, {faultFlagLowO, faultFlagLowOeN});
        faultDetect <= 0;
        repeat (6) @(posedge clk);
        chk("flag free", 1, faultFlagLowOeN);
        wr(`HBD_OFF_CTRL, 32'hC);
        repeat (2) @(posedge clk);
        chk("gain", 2'h3, ampGainSel);
        // Sleep with both inputs held high, then wake on a floating strap
        pins(5'h13);
        chk("sleep", 0, {gates, logicRegEn, analogRegEn, bridgeDriveEn});
        rdr(`HBD_OFF_STATE); chk("asleep", 1, rd[2]);
        pins(5'h14);
        pins(5'h14);
        rdr(`HBD_OFF_STATE); chk("mode", `HBD_MODE_PWM, rd[1:0]);
        runTable(1, 3'h5);
        pins(5'h0C);
        rdr(`HBD_OFF_STATE); chk("mode kept", `HBD_MODE_PWM, rd[1:0]);
        pins(5'h08);
        pins(5'h0C);
        pins(5'h0C);
        rdr(`HBD_OFF_STATE); chk("mode", `HBD_MODE_INDEP, rd[1:0]);
        runTable(2, 3'h3);
        chopTrip <= 1;
        pins(5'h0E);
        for (k = 0; k < 300 && gates === 4'h9; k++) @(posedge clk);
        chk("no chop", 300, k);
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
